//--- inc/ecsm_pkg.sv
// Package for the exception cause and shadow set map block
package ecsm_pkg;
    localparam int NUM_VEC      = 8;
    localparam int SS_W         = 4;
    localparam int VEC_W        = 3;
    localparam int CODE_W       = 5;
    localparam int CE_W         = 2;
    localparam int HW_IRQ_W     = 6;
    localparam int SW_IRQ_W     = 2;
    localparam int REQUESTED_PRIORITY_LEVEL_W       = 6;

    // Cause bit positions
    localparam int CAUSE_DS_BIT   = 31;
    localparam int CAUSE_TI_BIT   = 30;
    localparam int CAUSE_CE_LO    = 28;
    localparam int CAUSE_STOP_BIT = 27;
    localparam int CAUSE_PCI_BIT  = 26;
    localparam int CAUSE_IV_BIT   = 23;
    localparam int CAUSE_WD_BIT   = 22;
    localparam int CAUSE_IP_LO    = 10;
    localparam int CAUSE_SW_LO    = 8;
    localparam int CAUSE_CODE_LO  = 2;

    localparam logic [31:0] MAP_RESET = 32'h00000000;

    // Register selectors on the coprocessor access port
    typedef enum logic [0:0] {
        ECSM_SEL_MAP,
        ECSM_SEL_CAUSE
    } ecsm_sel_e;

    // Exception codes
    localparam logic [4:0] EXC_INT    = 5'h00;
    localparam logic [4:0] EXC_MOD    = 5'h01;
    localparam logic [4:0] EXC_TLB_LD = 5'h02;
    localparam logic [4:0] EXC_TLB_ST = 5'h03;
    localparam logic [4:0] EXC_ADR_LD = 5'h04;
    localparam logic [4:0] EXC_ADR_ST = 5'h05;
    localparam logic [4:0] EXC_BUS_I  = 5'h06;
    localparam logic [4:0] EXC_BUS_D  = 5'h07;
    localparam logic [4:0] EXC_SYSC   = 5'h08;
    localparam logic [4:0] EXC_BRK    = 5'h09;
    localparam logic [4:0] EXC_RSVD   = 5'h0a;
    localparam logic [4:0] EXC_CPUN   = 5'h0b;
    localparam logic [4:0] EXC_OVF    = 5'h0c;
    localparam logic [4:0] EXC_TRAP   = 5'h0d;
    localparam logic [4:0] EXC_FPE    = 5'h0f;
    localparam logic [4:0] EXC_WATCH  = 5'h17;
    localparam logic [4:0] EXC_MCHK   = 5'h18;

    // Interrupt entry offsets
    localparam logic [11:0] VEC_GENERAL = 12'h180;
    localparam logic [11:0] VEC_SPECIAL = 12'h200;
endpackage

//--- verilog/ecsm_map_lookup.sv
// Combinational shadow set lookup from the vector map
module ecsm_map_lookup
    import ecsm_pkg::*;
(
    input  wire logic [31:0]              map,
    input  wire logic [ecsm_pkg::VEC_W-1:0] vec,
    output logic      [ecsm_pkg::SS_W-1:0]  set
);
    logic [SS_W-1:0] field [NUM_VEC];

    genvar i;
    generate
        for (i = 0; i < NUM_VEC; i++)
        begin : g_field
            assign field[i] = map[i*SS_W +: SS_W]; // [RL3]
        end
    endgenerate

    assign set = field[vec]; // [RL25]
endmodule

//--- verilog/ecsm_top.sv
// Exception cause register and vector shadow set map
// What this block does
// RL1: Map register holds eight 4-bit shadow set fields, one per vector 0-7.
// RL2: Non-interrupts or non-vectored interrupts use the exception shadow set instead.
// RL3: Vector n occupies map bits 4n+3 down to 4n.
// RL4: All map fields are read/write and reset to zero.
// RL5: Many vectors may share one shadow set; no uniqueness check.
// RL6: Software avoids map access when highest shadow set is zero.
// RL7: Software never writes a map field above the highest shadow set.
// RL8: Only soft requests, count stop, vector select, deferred watch take writes.
// RL9: In controller mode bits 15..10 show requested priority level, zero none.
// RL10: Bit 31 records delay slot, updated only when exception level clear.
// RL11: Bit 30 shows timer interrupt pending.
// RL12: Bits 29..28 load referenced coprocessor unit on every exception.
// RL13: Bit 27 resets zero; when set the cycle counter stops.
// RL14: Bit 26 shows performance interrupt pending, zero when counters absent.
// RL15: Bit 23 selects interrupt offset 0x180 or 0x200.
// RL16: Bit 22 set on deferred watch; watch raised once both levels clear.
// RL17: Software avoids writing 1 to deferred watch bit while it reads 0.
// RL18: Without watch registers the deferred watch bit reads zero.
// RL19: Outside controller mode bits 15..10 show hardware interrupts 5..0.
// RL20: Bits 9..8 request soft interrupts and are exported to the controller.
// RL21: Bits 6..2 load the exception code on each exception; read-only.
// RL22: Reserved cause bits ignore writes and read zero.
// RL23: Exception codes use the standard encoding table.
// RL24: Vectored interrupt shadow set from map, or controller set in controller mode.
// RL25: Map lookup by vector index is combinational to the sequencer; next_shadow_set is registered, one cycle later.
module ecsm_top
    import ecsm_pkg::*;
#(
    parameter bit WATCH_PRESENT   = 1'b1,
    parameter bit PERF_PRESENT    = 1'b1,
    parameter bit EXT_CTRL_PRESENT = 1'b1
)
(
    input  wire logic                       clk,
    input  wire logic                       rst,
    // Coprocessor register access port
    input  wire logic                       reg_wr,
    input  wire logic                       reg_rd,
    input  wire logic                       reg_sel,
    input  wire logic [31:0]                reg_wdata,
    output logic      [31:0]                reg_rdata,
    // Configuration state from neighbouring registers
    input  wire logic                       external_irq_controller_mode,
    input  wire logic                       vectored_irq_present,
    input  wire logic [4:0]                 vector_spacing,
    input  wire logic                       exception_level,
    input  wire logic                       error_level,
    input  wire logic                       boot_vectors,
    input  wire logic [ecsm_pkg::SS_W-1:0]  exception_shadow_set,
    input  wire logic [ecsm_pkg::SS_W-1:0]  ext_ctrl_shadow_set,
    // Exception event from the sequencer
    input  wire logic                       exc_take,
    input  wire logic                       exc_is_irq,
    input  wire logic [ecsm_pkg::CODE_W-1:0] exc_code,
    input  wire logic                       exc_in_delay_slot,
    input  wire logic [ecsm_pkg::CE_W-1:0]  exc_cop_unit,
    input  wire logic [ecsm_pkg::VEC_W-1:0] irq_vector,
    // Interrupt sources, synchronous to clk
    input  wire logic [ecsm_pkg::HW_IRQ_W-1:0] hw_irq,
    input  wire logic [ecsm_pkg::REQUESTED_PRIORITY_LEVEL_W-1:0]   ext_requested_priority_level,
    input  wire logic                       timer_irq,
    input  wire logic                       perf_irq,
    input  wire logic                       watch_match,
    // Results
    output logic [ecsm_pkg::SS_W-1:0]       next_shadow_set,
    output logic [11:0]                     irq_entry_offset,
    output logic                            count_stop,
    output logic [ecsm_pkg::SW_IRQ_W-1:0]   sw_irq_request,
    output logic                            watch_exc_req
);
    logic [31:0]            vector_shadow_set_map;
    logic [31:0]            next_map;
    logic                   delay_slot_flag;
    logic                   next_delay_slot_flag;
    logic [CE_W-1:0]        cop_unit;
    logic [CE_W-1:0]        next_cop_unit;
    logic                   stop_bit;
    logic                   next_stop_bit;
    logic                   irq_vector_select;
    logic                   next_irq_vector_select;
    logic                   watch_deferred;
    logic                   next_watch_deferred;
    logic [SW_IRQ_W-1:0]    sw_req;
    logic [SW_IRQ_W-1:0]    next_sw_req;
    logic [CODE_W-1:0]      exception_code;
    logic [CODE_W-1:0]      next_exception_code;
    logic [HW_IRQ_W-1:0]    hw_irq_pending;
    logic [HW_IRQ_W-1:0]    next_hw_irq_pending;
    logic                   timer_irq_pending;
    logic                   perf_pending;
    logic [31:0]            cause_value;
    logic [31:0]            next_rdata;
    logic [SS_W-1:0]        map_set;
    logic [SS_W-1:0]        next_set;
    logic [11:0]            next_offset;
    logic                   next_watch_req;
    logic                   wr_map;
    logic                   wr_cause;
    logic                   levels_clear;
    logic                   vectored_irq;
    logic                   ctrl_irq;
    logic                   map_irq;

    // Lookup stays combinational, but next_shadow_set shows the set one cycle after it is asked for
    ecsm_map_lookup u_lookup
    (
        .map (vector_shadow_set_map),
        .vec (irq_vector),
        .set (map_set)
    );

    assign wr_map       = reg_wr && (reg_sel == ECSM_SEL_MAP);
    assign wr_cause     = reg_wr && (reg_sel == ECSM_SEL_CAUSE);
    assign levels_clear = !exception_level && !error_level;

    // Interrupt routing for the shadow set choice
    assign vectored_irq = exc_is_irq && irq_vector_select;
    assign ctrl_irq     = vectored_irq && EXT_CTRL_PRESENT && external_irq_controller_mode;
    assign map_irq      = vectored_irq && vectored_irq_present && (vector_spacing != '0);

    // Register state
    always_comb
    begin
        next_map               = vector_shadow_set_map;
        next_delay_slot_flag   = delay_slot_flag;
        next_cop_unit          = cop_unit;
        next_exception_code    = exception_code;
        next_stop_bit          = stop_bit;
        next_irq_vector_select = irq_vector_select;
        next_sw_req            = sw_req;
        next_watch_deferred    = watch_deferred;
        if (wr_map)
        begin
            // Fields are stored as written; no range or uniqueness check
            next_map = reg_wdata; // [RL1] [RL4] [RL5]
        end
        if (wr_cause)
        begin
            // Only the writable fields are taken [RL8] [RL22]
            next_stop_bit          = reg_wdata[CAUSE_STOP_BIT]; // [RL13]
            next_irq_vector_select = reg_wdata[CAUSE_IV_BIT]; // [RL15]
            next_sw_req            = reg_wdata[CAUSE_SW_LO +: SW_IRQ_W]; // [RL20]
            next_watch_deferred    = reg_wdata[CAUSE_WD_BIT];
        end
        if (exc_take)
        begin
            if (!exception_level)
            begin
                next_delay_slot_flag = exc_in_delay_slot; // [RL10]
            end
            next_cop_unit       = exc_cop_unit; // [RL12]
            next_exception_code = exc_code; // [RL21] [RL23]
            // Taking the watch exception itself consumes nothing; handler clears
        end
        // Hardware set wins over a software clear in the same cycle
        if (watch_match && !levels_clear)
        begin
            next_watch_deferred = 1'b1; // [RL16]
        end
        if (!WATCH_PRESENT)
        begin
            next_watch_deferred = 1'b0; // [RL18]
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            // Fields the hardware leaves undefined start at zero for repeatable reads
            vector_shadow_set_map <= MAP_RESET; // [RL4]
            delay_slot_flag       <= 1'b0;
            cop_unit              <= '0;
            exception_code        <= '0;
            stop_bit              <= 1'b0; // [RL13]
            irq_vector_select     <= 1'b0;
            sw_req                <= '0;
            watch_deferred        <= 1'b0;
        end
        else
        begin
            vector_shadow_set_map <= next_map;
            delay_slot_flag       <= next_delay_slot_flag;
            cop_unit              <= next_cop_unit;
            exception_code        <= next_exception_code;
            stop_bit              <= next_stop_bit;
            irq_vector_select     <= next_irq_vector_select;
            sw_req                <= next_sw_req;
            watch_deferred        <= next_watch_deferred;
        end
    end

    // Interrupt pending view, merging timer and performance into the top line
    // Sources share this clock, so one register stage is enough
    always_comb
    begin
        next_hw_irq_pending = hw_irq; // [RL19]
        next_hw_irq_pending[HW_IRQ_W-1] = hw_irq[HW_IRQ_W-1] | timer_irq
            | (PERF_PRESENT & perf_irq);
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            hw_irq_pending    <= '0;
            timer_irq_pending <= 1'b0;
            perf_pending      <= 1'b0;
        end
        else
        begin
            hw_irq_pending    <= next_hw_irq_pending;
            timer_irq_pending <= timer_irq; // [RL11]
            perf_pending      <= PERF_PRESENT & perf_irq; // [RL14]
        end
    end

    // Read value; reserved bits stay zero
    always_comb
    begin
        cause_value = '0; // [RL22]
        cause_value[CAUSE_DS_BIT]   = delay_slot_flag;
        cause_value[CAUSE_TI_BIT]   = timer_irq_pending;
        cause_value[CAUSE_CE_LO +: CE_W] = cop_unit;
        cause_value[CAUSE_STOP_BIT] = stop_bit;
        cause_value[CAUSE_PCI_BIT]  = perf_pending;
        cause_value[CAUSE_IV_BIT]   = irq_vector_select;
        cause_value[CAUSE_WD_BIT]   = watch_deferred;
        if (EXT_CTRL_PRESENT && external_irq_controller_mode)
        begin
            cause_value[CAUSE_IP_LO +: REQUESTED_PRIORITY_LEVEL_W] = ext_requested_priority_level; // [RL9]
        end
        else
        begin
            cause_value[CAUSE_IP_LO +: HW_IRQ_W] = hw_irq_pending; // [RL19]
        end
        cause_value[CAUSE_SW_LO +: SW_IRQ_W]  = sw_req;
        cause_value[CAUSE_CODE_LO +: CODE_W] = exception_code;
    end

    // Read data is registered so software sees a flop, at one cycle of latency
    always_comb
    begin
        next_rdata = reg_rdata;
        if (reg_rd)
        begin
            if (reg_sel == ECSM_SEL_MAP)
            begin
                next_rdata = vector_shadow_set_map;
            end
            else
            begin
                next_rdata = cause_value;
            end
        end
    end

    // Results for the sequencer, one cycle behind their inputs
    always_comb
    begin
        // Shadow set source selection
        if (ctrl_irq)
        begin
            next_set = ext_ctrl_shadow_set; // [RL24]
        end
        else if (map_irq)
        begin
            next_set = map_set; // [RL24] [RL25]
        end
        else
        begin
            next_set = exception_shadow_set; // [RL2]
        end
        // Boot vectors only affect base, not the offset choice
        next_offset = next_irq_vector_select ? VEC_SPECIAL : VEC_GENERAL; // [RL15]
        next_watch_req = next_watch_deferred && levels_clear && !boot_vectors
            || next_watch_deferred && levels_clear; // [RL16]
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            reg_rdata        <= '0;
            next_shadow_set  <= '0;
            irq_entry_offset <= VEC_GENERAL;
            count_stop       <= 1'b0;
            sw_irq_request   <= '0;
            watch_exc_req    <= 1'b0;
        end
        else
        begin
            reg_rdata        <= next_rdata;
            next_shadow_set  <= next_set;
            irq_entry_offset <= next_offset;
            // Taken from the same next value as bit 27, so the two never differ
            count_stop       <= next_stop_bit; // [RL13]
            sw_irq_request   <= next_sw_req; // [RL20]
            watch_exc_req    <= next_watch_req; // [RL16]
        end
    end
endmodule

//--- tb/ecsm_props.sv
// Concurrent checks on the cause and shadow set map ports
module ecsm_props (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic        reg_sel,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    input wire logic        exc_take,
    input wire logic [4:0]  exc_code,
    input wire logic        exception_level,
    input wire logic        error_level,
    input wire logic        count_stop,
    input wire logic [1:0]  sw_irq_request,
    input wire logic [11:0] irq_entry_offset,
    input wire logic        watch_exc_req
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence cause_wr; reg_wr && reg_sel; endsequence
    sequence cause_rd; reg_rd && reg_sel && !reg_wr && !exc_take; endsequence
    sequence map_wr; reg_wr && !reg_sel; endsequence
    sequence map_rd; reg_rd && !reg_sel && !reg_wr; endsequence
    stop_load_a: assert property (
        cause_wr |=> count_stop == $past(reg_wdata[27])) else $error("count stop not loaded");
    soft_req_a: assert property (
        cause_wr |=> sw_irq_request == $past(reg_wdata[9:8])) else $error("soft request wrong");
    entry_offset_a: assert property (
        cause_wr |=> irq_entry_offset == ($past(reg_wdata[23]) ? 12'h200 : 12'h180))
        else $error("entry offset wrong");
    write_only_a: assert property (
        !reg_wr |=> $stable(count_stop) && $stable(sw_irq_request)) else $error("field moved");
    code_read_a: assert property (
        exc_take ##1 !exc_take ##1 cause_rd |=> reg_rdata[6:2] == $past(exc_code, 3))
        else $error("exception code not recorded");
    reserved_zero_a: assert property (
        cause_rd |=> (reg_rdata & 32'h033f0083) == 32'h00000000) else $error("reserved bit set");
    map_back_a: assert property (
        map_wr ##1 !reg_wr ##1 map_rd |=> reg_rdata == $past(reg_wdata, 3))
        else $error("map readback wrong");
    watch_level_a: assert property (
        watch_exc_req |-> !$past(exception_level) && !$past(error_level))
        else $error("watch raised at high level");
endmodule
bind ecsm_top ecsm_props u_props (.*);

//--- tb/ecsm_partner.sv
// Model of the exception sequencer and external interrupt controller
module ecsm_partner (
    input  wire logic       clk,
    input  wire logic [1:0] sw_irq_request,     // Exported soft requests
    output logic            exc_take = 1'b0,
    output logic [4:0]      exc_code = 5'h00,
    output logic            exc_in_delay_slot = 1'b0,
    output logic [1:0]      exc_cop_unit = 2'h0,
    output logic            watch_match = 1'b0,
    output logic [5:0]      ext_requested_priority_level = 6'h00,
    output logic [3:0]      ext_ctrl_shadow_set = 4'h0
);
    timeunit 1ns;
    timeprecision 1ps;
    // One-cycle event; qualifiers go stale afterwards so a late sample shows up
    task take(input logic [4:0] c, input logic d, input logic [1:0] u);
        @(posedge clk);
        exc_take <= 1'b1;
        exc_code <= c;
        exc_in_delay_slot <= d;
        exc_cop_unit <= u;
        @(posedge clk);
        exc_take <= 1'b0;
        exc_code <= ~c;
        exc_in_delay_slot <= ~d;
        exc_cop_unit <= ~u;
    endtask
    task watch();
        @(posedge clk);
        watch_match <= 1'b1;
        @(posedge clk);
        watch_match <= 1'b0;
    endtask
    task prio(input logic [5:0] l, input logic [3:0] s);
        @(posedge clk);
        ext_requested_priority_level <= l;
        ext_ctrl_shadow_set <= s;
    endtask
endmodule

//--- tb/tb.sv
// Register level testbench for the cause and shadow set map block
`define CK(a, b) begin total_checks++; if ((a) !== (b)) begin num_errors++; \
    $display("[FAIL] %0t %h %h", $time, a, b); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, reg_sel = 1'b0;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    logic        external_irq_controller_mode = 1'b0, vectored_irq_present = 1'b0;
    logic        exception_level = 1'b0, error_level = 1'b0, boot_vectors = 1'b0;
    logic        exc_is_irq = 1'b0, timer_irq = 1'b0, perf_irq = 1'b0;
    logic [4:0]  vector_spacing = 5'h0, exc_code;
    logic [3:0]  exception_shadow_set = 4'h0, ext_ctrl_shadow_set, next_shadow_set;
    logic [2:0]  irq_vector = 3'h0;
    logic [5:0]  hw_irq = 6'h0, ext_requested_priority_level;
    logic        exc_take, exc_in_delay_slot, watch_match, count_stop, watch_exc_req;
    logic [1:0]  exc_cop_unit, sw_irq_request;
    logic [11:0] irq_entry_offset;
    int          num_errors = 0, total_checks = 0;
    always #2.5 clk = ~clk;
    ecsm_top DUT (.*);
    ecsm_partner p (.*);
    task conclude();
        $display("errors %0d checks %0d", num_errors, total_checks);
        if (num_errors == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task wr(input logic s, input logic [31:0] d);
        @(posedge clk);
        reg_sel <= s;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task chk(input logic s, input logic [31:0] e);
        @(posedge clk);
        reg_sel <= s;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        `CK(reg_rdata, e)
    endtask
    // Whole run is a little over 200 cycles; the 4000-cycle limit allows about eighteen times that
    initial
    begin
        #20000;
        num_errors++;
        conclude();
    end
    initial
    begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        chk(1'b0, 32'h0);
        chk(1'b1, 32'h0);
        `CK(irq_entry_offset, 12'h180)
        // Bit 22 reads 0 here, so the write leaves it clear
        wr(1'b1, 32'hffbfffff);
        chk(1'b1, 32'h08800300);
        `CK(count_stop, 1'b1)
        `CK(sw_irq_request, 2'h3)
        `CK(irq_entry_offset, 12'h200)
        `CK(watch_exc_req, 1'b0)
        wr(1'b1, 32'h0);
        `CK(count_stop, 1'b0)
        `CK(sw_irq_request, 2'h0)
        // Assumes eight or more shadow sets, so every field written is legal
        wr(1'b0, 32'h01234567);
        chk(1'b0, 32'h01234567);
        wr(1'b1, 32'h00800000);
        @(posedge clk);
        vectored_irq_present <= 1'b1;
        vector_spacing <= 5'h01;
        exc_is_irq <= 1'b1;
        exception_shadow_set <= 4'ha;
        for (int v = 0; v < 8; v++)
        begin
            @(posedge clk);
            irq_vector <= v[2:0];
            cyc(2);
            `CK(next_shadow_set, 4'(7 - v))
        end
        wr(1'b0, 32'h55555555);
        cyc(2);
        `CK(next_shadow_set, 4'h5)
        @(posedge clk);
        vector_spacing <= 5'h00;
        cyc(2);
        `CK(next_shadow_set, 4'ha)
        @(posedge clk);
        vector_spacing <= 5'h01;
        exc_is_irq <= 1'b0;
        cyc(2);
        `CK(next_shadow_set, 4'ha)
        @(posedge clk);
        exc_is_irq <= 1'b1;
        external_irq_controller_mode <= 1'b1;
        p.prio(6'h3f, 4'h9);
        cyc(2);
        `CK(next_shadow_set, 4'h9)
        wr(1'b1, 32'h0);
        cyc(1);
        `CK(next_shadow_set, 4'ha)
        chk(1'b1, 32'h0000fc00);
        p.prio(6'h00, 4'h9);
        cyc(2);
        chk(1'b1, 32'h0);
        @(posedge clk);
        external_irq_controller_mode <= 1'b0;
        hw_irq <= 6'h2a;
        cyc(2);
        chk(1'b1, 32'h0000a800);
        @(posedge clk);
        hw_irq <= 6'h00;
        timer_irq <= 1'b1;
        cyc(2);
        chk(1'b1, 32'h40008000);
        @(posedge clk);
        timer_irq <= 1'b0;
        perf_irq <= 1'b1;
        cyc(2);
        chk(1'b1, 32'h04008000);
        @(posedge clk);
        perf_irq <= 1'b0;
        cyc(2);
        for (int i = 0; i < 25; i++)
        begin
            p.take(i[4:0], i[0], i[2:1]);
            chk(1'b1, {i[0], 1'b0, i[2:1], 21'h0, i[4:0], 2'h0});
        end
        @(posedge clk);
        exception_level <= 1'b1;
        p.take(5'h0b, 1'b1, 2'h1);
        chk(1'b1, 32'h1000002c);
        p.watch();
        chk(1'b1, 32'h1040002c);
        `CK(watch_exc_req, 1'b0)
        @(posedge clk);
        exception_level <= 1'b0;
        cyc(2);
        `CK(watch_exc_req, 1'b1)
        wr(1'b1, 32'h0);
        cyc(2);
        `CK(watch_exc_req, 1'b0)
        @(posedge clk);
        error_level <= 1'b1;
        p.watch();
        chk(1'b1, 32'h1040002c);
        `CK(watch_exc_req, 1'b0)
        @(posedge clk);
        error_level <= 1'b0;
        cyc(2);
        `CK(watch_exc_req, 1'b1)
        wr(1'b1, 32'h0);
        cyc(1);
        `CK(watch_exc_req, 1'b0)
        conclude();
    end
endmodule
